/* srx_mode_status.sv */
`timescale 1ns/1ps
`default_nettype none
module srx_mode_status #(
  parameter int LOCK_CNT_W = srx_pkg::LOCK_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [srx_pkg::ADDR_W-1:0] paddr,
  input wire logic [srx_pkg::DATA_W-1:0] pwdata,
  output logic [srx_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // plain mode inputs
  input wire logic master_select,
  input wire logic input_select,
  input wire logic bus_width_select,
  input wire logic carrier_detect_a,
  input wire logic carrier_detect_b,
  // two-way mode pins
  input wire logic async_stream_mode_in,
  output logic async_stream_mode_out,
  output logic async_stream_mode_oe,
  input wire logic rate_select_in,
  output logic rate_select_out,
  output logic rate_select_oe,
  input wire logic reclock_select_in,
  output logic reclock_select_out,
  output logic reclock_select_oe,
  input wire logic video_processing_enable_in,
  output logic video_processing_enable_out,
  output logic video_processing_enable_oe,
  // serial inputs
  input wire logic serial_in_a,
  input wire logic serial_in_b,
  // detector results from the datapath
  input wire logic det_compliant,
  input wire logic det_hd,
  input wire logic det_asi,
  input wire logic anc_luma,
  input wire logic anc_chroma,
  // datapath controls and status
  output logic serial_sel,
  output logic loop_reclock,
  output logic asi_decode_en,
  output logic video_proc_en,
  output logic out_mute,
  output logic lock_flag,
  output logic luma_anc_flag
);
  initial
  begin
    if (LOCK_CNT_W < 1 || LOCK_CNT_W > srx_pkg::LOCK_W)
    begin
      $error("srx_mode_status: LOCK_CNT_W out of range");
    end
  end

  // ==========================================================
  // pin synchronisation
  logic [srx_pkg::SYNC_W-1:0] pins_raw;
  logic [srx_pkg::SYNC_W-1:0] pins_s;

  assign pins_raw = {carrier_detect_b, carrier_detect_a, bus_width_select, input_select,
                     video_processing_enable_in, reclock_select_in, rate_select_in,
                     async_stream_mode_in, master_select};

  srx_sync #(.WIDTH(srx_pkg::SYNC_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  logic master_s;
  logic cd_sel_s;
  assign master_s = pins_s[srx_pkg::SY_MASTER];
  assign cd_sel_s = pins_s[srx_pkg::SY_INSEL] ? pins_s[srx_pkg::SY_CD_A]
                                             : pins_s[srx_pkg::SY_CD_B];

  function automatic srx_pkg::srx_mode_e slave_mode(input logic async_m, input logic rate_m,
                                                    input logic vpe_m);
    if (async_m && rate_m && !vpe_m)
    begin
      slave_mode = srx_pkg::SRX_MODE_ASI;
    end
    else if (vpe_m && !async_m)
    begin
      slave_mode = srx_pkg::SRX_MODE_VIDEO;
    end
    else
    begin
      slave_mode = srx_pkg::SRX_MODE_DATA;
    end
  endfunction

  // ==========================================================
  // control register
  logic [srx_pkg::LOCK_W-1:0] ctrl_lock_reg;
  logic apb_access;
  logic apb_done;
  assign apb_access = psel && penable && !pready;
  // a write lands on the edge that completes the transfer, never before pready is seen
  assign apb_done = psel && penable && pready;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_lock_reg <= srx_pkg::CTRL_LOCK_RESET;
    end
    else if (apb_done && pwrite && paddr == srx_pkg::CTRL_OFFSET)
    begin
      ctrl_lock_reg <= pwdata[srx_pkg::CTRL_LOCK_LSB +: srx_pkg::LOCK_W];
    end
  end

  // ==========================================================
  // operating mode
  srx_pkg::srx_mode_e mode_reg;
  srx_pkg::srx_mode_e mode_next;
  srx_pkg::srx_lock_e lock_reg;
  logic asi_seen_reg;
  logic sd_seen_reg;

  always_comb
  begin
    if (master_s)
    begin
      mode_next = asi_seen_reg ? srx_pkg::SRX_MODE_ASI : srx_pkg::SRX_MODE_VIDEO;
    end
    else
    begin
      // pin codes other than the video and ASI ones fall to data-through; reclocking still follows the reclock pin
      mode_next = slave_mode(pins_s[srx_pkg::SY_ASYNC], pins_s[srx_pkg::SY_RATE],
                             pins_s[srx_pkg::SY_VPE]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg <= srx_pkg::SRX_MODE_DATA;
    end
    else
    begin
      mode_reg <= mode_next;
    end
  end

  // ==========================================================
  // lock search
  logic [srx_pkg::LOCK_W-1:0] lock_cnt_reg;
  logic rate_match;
  logic good;

  // in slave mode a stream of the wrong rate never locks; the controller resets on rate change
  assign rate_match = master_s || (det_hd == !pins_s[srx_pkg::SY_RATE]);
  always_comb
  begin
    case (mode_next)
      srx_pkg::SRX_MODE_VIDEO: good = det_compliant && !det_asi && rate_match;
      srx_pkg::SRX_MODE_ASI: good = det_compliant && det_asi && rate_match;
      default: good = master_s && det_compliant;
    endcase
    if (cd_sel_s)
    begin
      good = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_reg <= srx_pkg::SRX_SEARCH;
      lock_cnt_reg <= '0;
    end
    else
    begin
      case (lock_reg)
        srx_pkg::SRX_SEARCH:
        begin
          if (!good)
          begin
            lock_cnt_reg <= '0;
          end
          else if (lock_cnt_reg + 8'h01 >= ctrl_lock_reg)
          begin
            lock_reg <= srx_pkg::SRX_LOCKED;
            lock_cnt_reg <= '0;
          end
          else
          begin
            lock_cnt_reg <= lock_cnt_reg + 8'h01;
          end
        end
        srx_pkg::SRX_LOCKED:
        begin
          if (!good)
          begin
            lock_reg <= srx_pkg::SRX_SEARCH;
          end
        end
        default: lock_reg <= srx_pkg::SRX_SEARCH;
      endcase
    end
  end

  // stream type as detected, held while the stream is not compliant or the carrier is lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      asi_seen_reg <= 1'b0;
      sd_seen_reg <= 1'b0;
    end
    else if (det_compliant && !cd_sel_s)
    begin
      asi_seen_reg <= det_asi;
      sd_seen_reg <= !det_hd;
    end
  end

  logic locked;
  assign locked = (lock_reg == srx_pkg::SRX_LOCKED);

  // ==========================================================
  // mode pins: direction and driven values
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      async_stream_mode_oe <= 1'b0;
      rate_select_oe <= 1'b0;
      reclock_select_oe <= 1'b0;
      video_processing_enable_oe <= 1'b0;
      async_stream_mode_out <= 1'b0;
      rate_select_out <= 1'b0;
      reclock_select_out <= 1'b0;
      video_processing_enable_out <= 1'b0;
    end
    else
    begin
      async_stream_mode_oe <= master_s;
      rate_select_oe <= master_s;
      reclock_select_oe <= master_s;
      video_processing_enable_oe <= master_s;
      async_stream_mode_out <= locked && asi_seen_reg;
      rate_select_out <= sd_seen_reg;
      reclock_select_out <= locked;
      video_processing_enable_out <= locked && !asi_seen_reg;
    end
  end

  // ==========================================================
  // datapath controls and status flags
  logic rate_sd;
  assign rate_sd = master_s ? sd_seen_reg : pins_s[srx_pkg::SY_RATE];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_sel <= 1'b0;
      loop_reclock <= 1'b0;
      asi_decode_en <= 1'b0;
      video_proc_en <= 1'b0;
      out_mute <= 1'b0;
      lock_flag <= 1'b0;
    end
    else
    begin
      serial_sel <= pins_s[srx_pkg::SY_INSEL] ? serial_in_a : serial_in_b;
      loop_reclock <= master_s ? locked : pins_s[srx_pkg::SY_RECLOCK];
      // async low in slave leaves ASI mode out of reach, so no alignment or decode
      asi_decode_en <= (mode_next == srx_pkg::SRX_MODE_ASI) && (!master_s || locked);
      video_proc_en <= (mode_next == srx_pkg::SRX_MODE_VIDEO);
      out_mute <= cd_sel_s;
      lock_flag <= locked && !cd_sel_s && (mode_next != srx_pkg::SRX_MODE_DATA);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      luma_anc_flag <= 1'b0;
    end
    else if (!locked || cd_sel_s || mode_next != srx_pkg::SRX_MODE_VIDEO)
    begin
      luma_anc_flag <= 1'b0;
    end
    else if (!rate_sd || pins_s[srx_pkg::SY_BUSW])
    begin
      luma_anc_flag <= anc_luma;
    end
    else
    begin
      luma_anc_flag <= anc_luma || anc_chroma;
    end
  end

  // ==========================================================
  // apb read path; one wait state on every access
  logic [srx_pkg::DATA_W-1:0] status_word;
  always_comb
  begin
    status_word = '0;
    status_word[srx_pkg::ST_MASTER] = master_s;
    status_word[srx_pkg::ST_LOCKED] = lock_flag;
    status_word[srx_pkg::ST_ASI] = asi_decode_en;
    status_word[srx_pkg::ST_RATE_SD] = rate_sd;
    status_word[srx_pkg::ST_RECLOCK] = loop_reclock;
    status_word[srx_pkg::ST_VPE] = video_proc_en;
    status_word[srx_pkg::ST_CD_LOST] = out_mute;
    status_word[srx_pkg::ST_LUMA_ANC] = luma_anc_flag;
    status_word[srx_pkg::ST_MODE_MSB:srx_pkg::ST_MODE_LSB] = mode_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= apb_access;
      pslverr <= apb_access && paddr != srx_pkg::CTRL_OFFSET && paddr != srx_pkg::STATUS_OFFSET;
      if (apb_access && !pwrite && paddr == srx_pkg::CTRL_OFFSET)
      begin
        prdata <= {{(srx_pkg::DATA_W-srx_pkg::LOCK_W){1'b0}}, ctrl_lock_reg};
      end
      else if (apb_access && !pwrite && paddr == srx_pkg::STATUS_OFFSET)
      begin
        prdata <= status_word;
      end
      else
      begin
        prdata <= '0;
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_carrier_lost;
    cd_sel_s ##1 1'b1;
  endsequence

  sequence s_master_lock_rise;
    master_s && !locked ##1 master_s && locked;
  endsequence

  chk_pin_direction: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (reclock_select_oe == $past(master_s)) && (rate_select_oe == $past(master_s))
             && (async_stream_mode_oe == $past(master_s))
             && (video_processing_enable_oe == $past(master_s)))
    else $error("mode pin enable does not follow master select");

  chk_reclock_lock: assert property (@(posedge pclk) disable iff (!presetn)
    s_master_lock_rise |=> reclock_select_out && loop_reclock)
    else $error("reclock not raised after lock");

  chk_unlock_buffer: assert property (@(posedge pclk) disable iff (!presetn)
    master_s && !locked |=> !loop_reclock && !reclock_select_out)
    else $error("loop reclocked while unlocked in master mode");

  chk_slave_reclock: assert property (@(posedge pclk) disable iff (!presetn)
    !master_s |=> loop_reclock == $past(pins_s[srx_pkg::SY_RECLOCK]))
    else $error("slave loop path does not follow reclock pin");

  chk_carrier_mute: assert property (@(posedge pclk) disable iff (!presetn)
    s_carrier_lost |-> out_mute && !lock_flag && !luma_anc_flag)
    else $error("carrier loss did not mute and unlock");

  chk_async_locked: assert property (@(posedge pclk) disable iff (!presetn)
    async_stream_mode_out |-> $past(locked) && $past(asi_seen_reg))
    else $error("async mode driven without asi lock");

  chk_slave_asi_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !master_s && !pins_s[srx_pkg::SY_ASYNC] |=> !asi_decode_en)
    else $error("asi decode enabled with async pin low");

  chk_anc_mux10: assert property (@(posedge pclk) disable iff (!presetn)
    locked && !cd_sel_s && mode_next == srx_pkg::SRX_MODE_VIDEO && rate_sd
    && !pins_s[srx_pkg::SY_BUSW] |=> luma_anc_flag == $past(anc_luma || anc_chroma))
    else $error("multiplexed sd ancillary flag wrong");

  chk_input_pick: assert property (@(posedge pclk) disable iff (!presetn)
    pins_s[srx_pkg::SY_INSEL] |=> serial_sel == $past(serial_in_a))
    else $error("input A not selected");

  chk_input_pick_b: assert property (@(posedge pclk) disable iff (!presetn)
    !pins_s[srx_pkg::SY_INSEL] |=> serial_sel == $past(serial_in_b))
    else $error("input B not selected");
endmodule
`default_nettype wire

/* srx_pkg.sv */
`default_nettype none
package srx_pkg;
  // ==========================================================
  // register map
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // ==========================================================
  // control fields
  localparam int CTRL_LOCK_LSB = 0;
  localparam int LOCK_W = 8;
  localparam logic [7:0] CTRL_LOCK_RESET = 8'h10;
  // ==========================================================
  // status fields
  localparam int ST_MASTER = 0;
  localparam int ST_LOCKED = 1;
  localparam int ST_ASI = 2;
  localparam int ST_RATE_SD = 3;
  localparam int ST_RECLOCK = 4;
  localparam int ST_VPE = 5;
  localparam int ST_CD_LOST = 6;
  localparam int ST_LUMA_ANC = 7;
  localparam int ST_MODE_LSB = 8;
  localparam int ST_MODE_MSB = 9;
  // ==========================================================
  // synchronised pin vector positions
  localparam int SYNC_W = 9;
  localparam int SY_MASTER = 0;
  localparam int SY_ASYNC = 1;
  localparam int SY_RATE = 2;
  localparam int SY_RECLOCK = 3;
  localparam int SY_VPE = 4;
  localparam int SY_INSEL = 5;
  localparam int SY_BUSW = 6;
  localparam int SY_CD_A = 7;
  localparam int SY_CD_B = 8;
  // ==========================================================
  // operating modes and lock states
  typedef enum logic [1:0] {
    SRX_MODE_DATA,
    SRX_MODE_VIDEO,
    SRX_MODE_ASI
  } srx_mode_e;
  typedef enum logic {
    SRX_SEARCH,
    SRX_LOCKED
  } srx_lock_e;
endpackage
`default_nettype wire

/* srx_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module srx_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("srx_sync: WIDTH must be at least 1");
    end
  end

  // stage1 is read only by the second flop; nothing else may look at it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule
`default_nettype wire

/* srx_app_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// application-side controller of the four two-way mode pins
module srx_app_model (
  // clock
  input wire logic pclk,
  // controller settings, order vpe, reclock, rate, async
  input wire logic master_select,
  input wire logic [3:0] want,
  // device pin drivers
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] dev_out,
  // resolved pin levels
  output logic [3:0] pin
);
  logic [3:0] last_reg = 4'h0;
  always @(posedge pclk)
  begin
    last_reg <= pin;
  end
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (dev_oe[i])
        pin[i] = dev_out[i];
      else if (!master_select)
        pin[i] = want[i];
      else if (i == 1)
        pin[i] = 1'b1;
      else
        pin[i] = ~last_reg[i]; // undriven: keep moving so a stale level is never trusted
    end
  end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================
  // signals
  logic pclk;
  logic presetn;
  logic psel, penable, pwrite, snap;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  logic ms, isel, busw, cda, cdb, sa, sb, comp, hd, asi, al, ac;
  logic serial_sel, loop_reclock, asi_decode_en, video_proc_en, out_mute, lock_flag, luma_anc_flag;
  logic [3:0] want, pin, dev_oe, dev_out;
  int seed = 32'h6d2fe911;
  int n_mismatch = 0;
  int checked = 0;
  logic [64:0] q_apb[$];
  logic [31:0] q_pin[$];
  // ==========================================================
  // design and far side
  srx_mode_status uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_select(ms), .input_select(isel), .bus_width_select(busw),
    .carrier_detect_a(cda), .carrier_detect_b(cdb),
    .async_stream_mode_in(pin[0]), .async_stream_mode_out(dev_out[0]),
    .async_stream_mode_oe(dev_oe[0]), .rate_select_in(pin[1]), .rate_select_out(dev_out[1]),
    .rate_select_oe(dev_oe[1]), .reclock_select_in(pin[2]), .reclock_select_out(dev_out[2]),
    .reclock_select_oe(dev_oe[2]), .video_processing_enable_in(pin[3]),
    .video_processing_enable_out(dev_out[3]), .video_processing_enable_oe(dev_oe[3]),
    .serial_in_a(sa), .serial_in_b(sb), .det_compliant(comp), .det_hd(hd), .det_asi(asi),
    .anc_luma(al), .anc_chroma(ac), .serial_sel(serial_sel), .loop_reclock(loop_reclock),
    .asi_decode_en(asi_decode_en), .video_proc_en(video_proc_en), .out_mute(out_mute),
    .lock_flag(lock_flag), .luma_anc_flag(luma_anc_flag)
  );
  srx_app_model app (.pclk(pclk), .master_select(ms), .want(want), .dev_oe(dev_oe),
    .dev_out(dev_out), .pin(pin));
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ==========================================================
  // compare and closing tasks
  task cmp_apb(input logic [32:0] got, input logic [32:0] exp, input logic [32:0] m);
    checked++;
    if ((got & m) !== (exp & m))
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cmp_pins(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
    checked++;
    if ((got & m) !== (exp & m))
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task stop_test;
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // result watcher: oldest note is matched to each result
  always @(posedge pclk)
  begin
    logic [64:0] a;
    logic [31:0] p;
    if (pready === 1'b1)
    begin
      a = q_apb.pop_front();
      cmp_apb({prdata, pslverr}, {a[64:33], a[0]}, {a[32:1], 1'b1});
    end
    if (snap === 1'b1)
    begin
      p = q_pin.pop_front();
      cmp_pins({1'b0, serial_sel, loop_reclock, asi_decode_en, video_proc_en, out_mute,
        lock_flag, luma_anc_flag, dev_oe, dev_out}, p[31:16], p[15:0]);
    end
  end
  // ==========================================================
  // drivers
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
    input logic [31:0] m, input logic er);
    q_apb.push_back({e, m, er});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no assumed wait count: a slave that never answers is ended by the watchdog
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rst;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // expected levels worked out from the pin settings and detector levels
  task check;
    logic [15:0] e, m;
    logic cd, lk, am, vm;
    cd = isel ? cda : cdb;
    e = 16'h0000;
    m = 16'h7fff;
    if (ms)
    begin
      lk = comp & !cd;
      am = lk & asi;
      vm = lk & !asi;
      e[7:0] = {4'hf, vm, lk, !hd, am};
      m[1] = comp;
      if (!lk)
        m[12:11] = 2'b00;
    end
    else
    begin
      am = want[0] & want[1] & !want[3];
      vm = want[3] & !want[0];
      lk = comp & !cd & (hd == !want[1]) & (am | vm);
      m[3:0] = 4'h0;
    end
    e[14:8] = {isel ? sa : sb, ms ? lk : want[2], am, vm, cd, lk,
      lk & vm & ((hd | busw) ? al : (al | ac))};
    q_pin.push_back({e, m});
    snap <= 1'b1;
    @(posedge pclk);
    snap <= 1'b0;
    apb(1'b0, srx_pkg::STATUS_OFFSET, 32'h0, {25'h0, cd, 1'b0, e[13], 2'b00, lk, ms},
      32'h53, 1'b0);
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    int r;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    snap = 1'b0;
    {ms, isel, busw, cda, cdb, sa, sb, comp, hd, asi, al, ac} = 12'h000;
    want = 4'h0;
    rst;
    apb(1'b0, srx_pkg::CTRL_OFFSET, 32'h0, {24'h0, srx_pkg::CTRL_LOCK_RESET}, 32'hff, 1'b0);
    apb(1'b1, srx_pkg::CTRL_OFFSET, 32'ha5, 32'h0, 32'h0, 1'b0);
    apb(1'b0, srx_pkg::CTRL_OFFSET, 32'h0, 32'ha5, 32'hff, 1'b0);
    apb(1'b1, 12'h008, 32'h1, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 12'h00c, 32'h0, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b1, srx_pkg::STATUS_OFFSET, 32'hffffffff, 32'h0, 32'h0, 1'b0);
    // every slave pin code, then master with random detector levels
    for (int i = 0; i < 32; i++)
    begin
      r = $random(seed);
      ms <= i[4];
      want <= i[3:0];
      isel <= r[0];
      busw <= r[1];
      cda <= r[2] & r[3];
      cdb <= r[4] & r[5];
      sa <= r[6];
      sb <= r[7];
      comp <= r[8] | r[9];
      hd <= r[10];
      al <= r[11];
      ac <= r[12];
      asi <= i[4] ? r[13] : (i[0] & i[1] & !i[3]);
      rst;
      repeat (30) @(posedge pclk);
      check;
      // carrier lost on both inputs without a reset
      cda <= 1'b1;
      cdb <= 1'b1;
      repeat (30) @(posedge pclk);
      check;
    end
    stop_test;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    stop_test;
  end
endmodule
`default_nettype wire
